// file: design/ipa_pkg.sv
// constants shared by both ends of the indexed parameter link
package ipa_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // object addressing
   localparam logic [15:0] OBJ_BASE     = 16'h2000;
   localparam logic [15:0] PAR_WSEL     = 16'h04b0;
   localparam logic [15:0] PAR_RSEL     = 16'h04b1;
   localparam logic [15:0] PAR_MEMB0    = 16'h04b2;
   localparam logic [15:0] PAR_IN_MODE  = 16'h01c4;
   localparam logic [15:0] PAR_OUT_MODE = 16'h0226;
   localparam logic [15:0] MFR_LO       = 16'h3000;
   localparam logic [15:0] MFR_HI       = 16'h5fff;
   localparam logic [15:0] OBJ_DIN      = 16'h3001;
   localparam logic [15:0] OBJ_DOUT     = 16'h3002;

   ////////////////////////////////////////////////////////////////////////////
   // digital state objects
   localparam logic [7:0]  MODE_IN_DIG   = 8'h03;
   localparam logic [7:0]  MODE_OUT_DIG  = 8'h01;
   localparam logic [7:0]  MODE_RST      = 8'h00;
   localparam logic [15:0] DIN_MFI_MASK  = 16'h0040;
   localparam logic [15:0] DOUT_MFO_MASK = 16'h0004;
   localparam logic [7:0]  SEL_RST       = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // controller registers (byte addresses)
   localparam logic [3:0] HR_CMD     = 4'h0;
   localparam logic [3:0] HR_WDATA   = 4'h4;
   localparam logic [3:0] HR_STAT    = 4'h8;
   localparam logic [3:0] HR_RDATA   = 4'hc;
   localparam int         CMD_WR_BIT = 16;
   localparam int         ST_BUSY    = 0;
   localparam int         ST_DONE    = 1;
   localparam int         ST_ERR     = 2;

   typedef enum logic [0:0] {
      HS_IDLE = 1'b0,
      HS_WAIT = 1'b1
   } ipa_hstate_t;

endpackage

// file: design/ipa_link_if.sv
// request and answer link between controller and parameter device
`timescale 1ns/1ns
interface ipa_link_if;
   logic        req;
   logic        wr;
   logic [15:0] idx;
   logic [31:0] wdata;
   logic        ack;
   logic        err;
   logic [31:0] rdata;

   modport dev  (input req, wr, idx, wdata, output ack, err, rdata);
   modport host (output req, wr, idx, wdata, input ack, err, rdata);
endinterface

// file: design/ipa_sel_reg.sv
// index selector register with range check and decode
`timescale 1ns/1ns
module ipa_sel_reg import ipa_pkg::*; #(
   parameter int N    = 32,
   parameter int WSEL = 1,
   parameter int IW   = $clog2(N)
) (
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          arst_n,
   // load side
   input  wire logic          load,
   input  wire logic [7:0]    value,
   output      logic          ok,
   // stored selector
   output      logic [7:0]    sel_q,
   output      logic          all_q,
   output      logic          vol_q,
   output      logic [IW-1:0] pos_q
);
   localparam logic [7:0] NMAX     = 8'(N);
   localparam logic [7:0] ALL_VOL  = 8'(N + 1);
   localparam logic [7:0] VOL_BASE = 8'(N + 2);
   localparam logic [7:0] TOP      = 8'(2 * N + 1);
   localparam logic [7:0] ONE      = 8'h01;

   logic [7:0] sel_reg;
   wire  [7:0] off;

   assign ok    = (WSEL != 0) ? (value <= TOP) : (value >= ONE && value <= NMAX);
   assign sel_q = sel_reg;
   assign all_q = (sel_reg == SEL_RST) || (sel_reg == ALL_VOL);
   assign vol_q = sel_reg > NMAX;
   assign off   = vol_q ? sel_reg - VOL_BASE : sel_reg - ONE;
   assign pos_q = off[IW-1:0];

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sel_reg <= SEL_RST;
      end else if (load && ok) begin
         sel_reg <= value;
      end
   end
endmodule

// file: design/ipa_dev_end.sv
// parameter device end: indexed parameter access and digital state objects
//
// Design decision made here: the link device port (ipa_link_if.dev).
`timescale 1ns/1ns
// Notes on behaviour
// - object index is parameter number plus offset
// - selector zero writes all indexes non-volatile
// - selector 33 (N + 1) writes all volatile
// - single volatile index sits past non-volatile range
// - write selector is kept across member writes
// - master sets read selector before member reads
// - read selector is kept across member reads
// - master uses volatile targets for cyclic writes
// - volatile values lost on power loss
// - manufacturer objects sit in fixed index range
// - input state includes input 1 in mode 3
// - output state includes output 1 in mode 1
module ipa_dev_end import ipa_pkg::*; #(
   parameter int N    = 32,
   parameter int MEMB = 4,
   parameter int IW   = $clog2(N),
   parameter int MW   = $clog2(MEMB)
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   // link
   ipa_link_if.dev          link,
   // digital state
   input  wire logic [15:0] din,
   input  wire logic        mfi1,
   input  wire logic [15:0] dout,
   input  wire logic        mfo1,
   // supply
   input  wire logic        power_lost
);
   localparam int DEPTH = MEMB * N;
   localparam int AW    = MW + IW;

   ////////////////////////////////////////////////////////////////////////////
   // decode
   logic          ack_reg;
   logic          err_reg;
   logic [31:0]   rdata_reg;
   logic [7:0]    in_mode_reg;
   logic [7:0]    out_mode_reg;
   logic          err_next;
   logic [31:0]   rd_next;
   logic [31:0]   nv_mem  [DEPTH];
   logic [31:0]   vol_mem [DEPTH];
   logic [7:0]    wsel_q;
   logic [7:0]    rsel_q;
   logic          wsel_ok;
   logic          rsel_ok;
   logic          w_all;
   logic          w_vol;
   logic          r_all;
   logic          r_vol;
   logic [IW-1:0] w_pos;
   logic [IW-1:0] r_pos;

   wire        take     = link.req && !ack_reg;
   wire        wr_take  = take && link.wr;
   wire [15:0] ix       = link.idx;
   wire [15:0] memb_lo  = OBJ_BASE + PAR_MEMB0;
   wire [15:0] m_rel    = ix - memb_lo;
   wire [MW-1:0] m_sel  = m_rel[MW-1:0];
   wire        hit_wsel = ix == OBJ_BASE + PAR_WSEL;
   wire        hit_rsel = ix == OBJ_BASE + PAR_RSEL;
   wire        hit_memb = (ix >= memb_lo) && (m_rel < 16'(MEMB));
   wire        hit_imod = ix == OBJ_BASE + PAR_IN_MODE;
   wire        hit_omod = ix == OBJ_BASE + PAR_OUT_MODE;
   wire        hit_mfr  = (ix >= MFR_LO) && (ix <= MFR_HI);
   wire        hit_din  = hit_mfr && (ix == OBJ_DIN);
   wire        hit_dout = hit_mfr && (ix == OBJ_DOUT);
   wire        sel_hi0  = link.wdata[31:8] == 24'h000000;
   wire        mode_hi0 = link.wdata[31:8] == 24'h000000;
   wire        ld_wsel  = wr_take && hit_wsel && sel_hi0;
   wire        ld_rsel  = wr_take && hit_rsel && sel_hi0;
   wire        mfi_on   = (in_mode_reg == MODE_IN_DIG) && mfi1;
   wire        mfo_on   = (out_mode_reg == MODE_OUT_DIG) && mfo1;
   wire [15:0] din_view  = (din & ~DIN_MFI_MASK) | (mfi_on ? DIN_MFI_MASK : 16'h0000);
   wire [15:0] dout_view = (dout & ~DOUT_MFO_MASK) | (mfo_on ? DOUT_MFO_MASK : 16'h0000);
   wire        r_valid  = rsel_q != SEL_RST;
   wire [AW-1:0] r_addr = {m_sel, r_pos};
   wire [AW-1:0] w_addr = {m_sel, w_pos};
   wire        memb_wr  = wr_take && hit_memb;

   ////////////////////////////////////////////////////////////////////////////
   // storage control
   wire        fill_all = memb_wr && w_all;
   wire        nv_too   = !w_vol;
   wire [31:0] ans_data = link.wr ? 32'h00000000 : rd_next;

   ////////////////////////////////////////////////////////////////////////////
   // selectors
   ipa_sel_reg #(
      .N    (N),
      .WSEL (1)
   ) u_wsel (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .load    (ld_wsel),
      .value   (link.wdata[7:0]),
      .ok      (wsel_ok),
      .sel_q   (wsel_q),
      .all_q   (w_all),
      .vol_q   (w_vol),
      .pos_q   (w_pos)
   );

   ipa_sel_reg #(
      .N    (N),
      .WSEL (0)
   ) u_rsel (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .load    (ld_rsel),
      .value   (link.wdata[7:0]),
      .ok      (rsel_ok),
      .sel_q   (rsel_q),
      .all_q   (r_all),
      .vol_q   (r_vol),
      .pos_q   (r_pos)
   );

   ////////////////////////////////////////////////////////////////////////////
   // answer
   always_comb begin
      err_next = 1'b1;
      rd_next  = 32'h00000000;
      if (hit_wsel) begin
         err_next = link.wr && !(wsel_ok && sel_hi0);
         rd_next  = {24'h000000, wsel_q};
      end else if (hit_rsel) begin
         err_next = link.wr && !(rsel_ok && sel_hi0);
         rd_next  = {24'h000000, rsel_q};
      end else if (hit_memb) begin
         err_next = !link.wr && !r_valid;
         rd_next  = vol_mem[r_addr];
      end else if (hit_imod) begin
         err_next = link.wr && !mode_hi0;
         rd_next  = {24'h000000, in_mode_reg};
      end else if (hit_omod) begin
         err_next = link.wr && !mode_hi0;
         rd_next  = {24'h000000, out_mode_reg};
      end else if (hit_din) begin
         err_next = link.wr;
         rd_next  = {16'h0000, din_view};
      end else if (hit_dout) begin
         err_next = link.wr;
         rd_next  = {16'h0000, dout_view};
      end
   end

   assign link.ack   = ack_reg;
   assign link.err   = err_reg;
   assign link.rdata = rdata_reg;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_reg   <= 1'b0;
         err_reg   <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else begin
         ack_reg <= take;
         if (take) begin
            err_reg   <= err_next;
            rdata_reg <= ans_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode settings
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         in_mode_reg  <= MODE_RST;
         out_mode_reg <= MODE_RST;
      end else begin
         if (wr_take && hit_imod && mode_hi0) begin
            in_mode_reg <= link.wdata[7:0];
         end
         if (wr_take && hit_omod && mode_hi0) begin
            out_mode_reg <= link.wdata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // member storage
   always_ff @(posedge ref_clk) begin
      if (power_lost) begin
         for (int j = 0; j < DEPTH; j++) begin
            vol_mem[j] <= nv_mem[j];
         end
      end else if (fill_all) begin
         for (int k = 0; k < N; k++) begin
            vol_mem[{m_sel, IW'(k)}] <= link.wdata;
            if (nv_too) begin
               nv_mem[{m_sel, IW'(k)}] <= link.wdata;
            end
         end
      end else if (memb_wr) begin
         vol_mem[w_addr] <= link.wdata;
         if (nv_too) begin
            nv_mem[w_addr] <= link.wdata;
         end
      end
   end
endmodule

// file: design/ipa_host_end.sv
// controller end: avalon-mm command registers driving the parameter link
`timescale 1ns/1ns
module ipa_host_end import ipa_pkg::*; (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output      logic [31:0] avs_readdata,
   output      logic        avs_waitrequest,
   // link
   ipa_link_if.host         link
);
   ipa_hstate_t st_reg;
   ipa_hstate_t st_next;
   logic [15:0] idx_reg;
   logic        wr_reg;
   logic [31:0] wdata_reg;
   logic [31:0] rdata_reg;
   logic        done_reg;
   logic        err_reg;
   logic        rdv_reg;
   logic [31:0] rdmux;
   logic [31:0] rdata_out_reg;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   wire a_cmd   = avs_address == HR_CMD;
   wire a_wdata = avs_address == HR_WDATA;
   wire a_stat  = avs_address == HR_STAT;
   wire a_rdata = avs_address == HR_RDATA;
   wire busy    = st_reg == HS_WAIT;
   assign avs_waitrequest = (avs_read && !rdv_reg) || (avs_write && a_cmd && busy);
   wire wr_ok   = avs_write && !avs_waitrequest;
   wire launch  = wr_ok && a_cmd;
   wire done_ev = busy && link.ack;
   wire clr_done = wr_ok && a_stat && avs_writedata[ST_DONE];
   wire [31:0] stat_word = {29'h00000000, err_reg, done_reg, busy};

   assign rdmux = a_cmd   ? {15'h0000, wr_reg, idx_reg} :
                  a_wdata ? wdata_reg :
                  a_stat  ? stat_word :
                  a_rdata ? rdata_reg : 32'h00000000;

   assign avs_readdata = rdata_out_reg;

   ////////////////////////////////////////////////////////////////////////////
   // link side
   assign link.req   = busy;
   assign link.wr    = wr_reg;
   assign link.idx   = idx_reg;
   assign link.wdata = wdata_reg;

   always_comb begin
      case (st_reg)
         HS_IDLE: st_next = launch ? HS_WAIT : HS_IDLE;
         HS_WAIT: st_next = link.ack ? HS_IDLE : HS_WAIT;
         default: st_next = HS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg        <= HS_IDLE;
         idx_reg       <= 16'h0000;
         wr_reg        <= 1'b0;
         wdata_reg     <= 32'h00000000;
         rdata_reg     <= 32'h00000000;
         done_reg      <= 1'b0;
         err_reg       <= 1'b0;
         rdv_reg       <= 1'b0;
         rdata_out_reg <= 32'h00000000;
      end else begin
         st_reg   <= st_next;
         rdv_reg  <= avs_read && !rdv_reg;
         done_reg <= done_ev || (done_reg && !clr_done);
         if (avs_read && !rdv_reg) begin
            rdata_out_reg <= rdmux;
         end
         if (launch) begin
            idx_reg <= avs_writedata[15:0];
            wr_reg  <= avs_writedata[CMD_WR_BIT];
         end
         if (wr_ok && a_wdata) begin
            wdata_reg <= avs_writedata;
         end
         if (done_ev) begin
            err_reg   <= link.err;
            rdata_reg <= link.rdata;
         end
      end
   end
endmodule

// file: verif/ipa_link_chk.sv
// assertions on the link between controller and parameter device
`timescale 1ns/1ns
module ipa_link_chk import ipa_pkg::*; #(
   parameter int N = 32
) (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        arst_n,
   // link
   input wire logic        req,
   input wire logic        wr,
   input wire logic [15:0] idx,
   input wire logic [31:0] wdata,
   input wire logic        ack,
   input wire logic        err,
   input wire logic [31:0] rdata
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   wire take = req && !ack;

   ////////////////////////////////////////////////////////////////////////////
   // sequences
   sequence s_wr_to(logic [15:0] o);
      take && wr && idx == o;
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   // properties
   property p_ack_next; take |=> ack; endproperty
   property p_ack_pulse; ack |=> !ack; endproperty
   property p_ack_cause; ack |-> $past(take); endproperty
   property p_req_drop; req && ack |=> !req; endproperty
   property p_wr_zero; ack && $past(wr) |-> rdata == 32'h0; endproperty
   property p_state_ro; s_wr_to(OBJ_DIN) or s_wr_to(OBJ_DOUT) |=> ack && err; endproperty
   property p_wsel_bad; s_wr_to(OBJ_BASE + PAR_WSEL) ##0 (wdata > 2 * N + 1) |=> ack && err; endproperty
   property p_rsel_zero; s_wr_to(OBJ_BASE + PAR_RSEL) ##0 (wdata == 32'h0) |=> ack && err; endproperty
   property p_low_err; take && idx < OBJ_BASE |=> ack && err; endproperty

   a_ack_next: assert property (p_ack_next) else $error("no answer after request");
   a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than one cycle");
   a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
   a_req_drop: assert property (p_req_drop) else $error("request held after answer");
   a_wr_zero: assert property (p_wr_zero) else $error("read data not zero on write");
   a_state_ro: assert property (p_state_ro) else $error("state object write accepted");
   a_wsel_bad: assert property (p_wsel_bad) else $error("bad write selector accepted");
   a_rsel_zero: assert property (p_rsel_zero) else $error("zero read selector accepted");
   a_low_err: assert property (p_low_err) else $error("unmapped index accepted");
endmodule

// file: verif/tb_top.sv
// self-checking bench for both ends of the parameter link
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top import ipa_pkg::*; ;
   localparam logic [15:0] WS = OBJ_BASE + PAR_WSEL;
   localparam logic [15:0] RS = OBJ_BASE + PAR_RSEL;
   localparam logic [15:0] M0 = OBJ_BASE + PAR_MEMB0;
   localparam logic [15:0] M1 = M0 + 16'h0001;
   localparam logic [31:0] DOUT_CMD = {16'h0000, OBJ_DOUT};
   logic        ref_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [15:0] din = 16'h0;
   logic [15:0] dout = 16'h0;
   logic        mfi1 = 1'b0;
   logic        mfo1 = 1'b0;
   logic        power_lost = 1'b0;
   logic [31:0] q0;
   int          fail_count = 0;
   int          total_checks = 0;

   always #5 ref_clk = ~ref_clk;

   ipa_link_if link ();
   ipa_host_end u_ipa_host_end (.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link));
   ipa_dev_end #(.N(32), .MEMB(4)) u_ipa_dev_end (.ref_clk(ref_clk), .arst_n(arst_n), .link(link),
      .din(din), .mfi1(mfi1), .dout(dout), .mfo1(mfo1), .power_lost(power_lost));
   ipa_link_chk #(.N(32)) u_ipa_link_chk (.ref_clk(ref_clk), .arst_n(arst_n), .req(link.req),
      .wr(link.wr), .idx(link.idx), .wdata(link.wdata), .ack(link.ack), .err(link.err), .rdata(link.rdata));

   ////////////////////////////////////////////////////////////////////////////
   // bus and link tasks
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic op(input logic w, input logic [15:0] i, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
      logic [31:0] s;
      av(1'b1, HR_WDATA, d, s);
      av(1'b1, HR_CMD, {15'h0, w, i}, s);
      s = 32'h0;
      while (s[ST_DONE] !== 1'b1) av(1'b0, HR_STAT, 32'h0, s);
      e = s[ST_ERR];
      av(1'b0, HR_RDATA, 32'h0, q);
      av(1'b1, HR_STAT, 32'h2, s);
   endtask
   task automatic pw(input logic [15:0] i, input logic [31:0] d, input logic ee);
      logic [31:0] q;
      logic        e;
      op(1'b1, i, d, q, e);
      `CHK(e, ee)
   endtask
   task automatic pr(input logic [15:0] i, input logic [31:0] x, input logic ee);
      logic [31:0] q;
      logic        e;
      op(1'b0, i, 32'h0, q, e);
      `CHK(e, ee)
      if (!ee) `CHK(q, x)
   endtask
   task automatic pl;
      @(posedge ref_clk);
      power_lost <= 1'b1;
      @(posedge ref_clk);
      power_lost <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_single;
      pr(M0, 32'h0, 1'b1);
      pw(WS, 32'd1, 1'b0);
      pw(M0, 32'h11, 1'b0);
      pw(M1, 32'h22, 1'b0);
      pw(WS, 32'd34, 1'b0);
      pw(M0, 32'd30000, 1'b0);
      pw(M1, 32'h33, 1'b0);
      pw(RS, 32'd1, 1'b0);
      pr(M0, 32'd30000, 1'b0);
      pr(M1, 32'h33, 1'b0);
      pl();
      pr(M0, 32'h11, 1'b0);
      pr(M1, 32'h22, 1'b0);
      pw(M0, 32'd30000, 1'b0);
      pr(M0, 32'd30000, 1'b0);
      $display("test single index done");
   endtask
   task automatic t_all;
      pw(WS, 32'd0, 1'b0);
      pw(M0, 32'h5a5a, 1'b0);
      pw(RS, 32'd1, 1'b0);
      pr(M0, 32'h5a5a, 1'b0);
      pw(RS, 32'd32, 1'b0);
      pr(M0, 32'h5a5a, 1'b0);
      pw(WS, 32'd33, 1'b0);
      pw(M0, 32'h77, 1'b0);
      pr(M0, 32'h77, 1'b0);
      pl();
      pr(M0, 32'h5a5a, 1'b0);
      $display("test all indexes done");
   endtask
   task automatic t_bad;
      pw(WS, 32'd1, 1'b0);
      pw(WS, 32'd66, 1'b1);
      pw(WS, 32'h100, 1'b1);
      pw(M0, 32'hbeef, 1'b0);
      pw(RS, 32'd1, 1'b0);
      pw(RS, 32'd0, 1'b1);
      pw(RS, 32'd33, 1'b1);
      pr(M0, 32'hbeef, 1'b0);
      pr(WS, 32'd1, 1'b0);
      av(1'b0, 4'h2, 32'h0, q0);
      `CHK(q0, 32'h0)
      $display("test bad selectors done");
   endtask
   task automatic t_state;
      @(posedge ref_clk);
      din <= 16'hffff;
      dout <= 16'h00f0;
      mfi1 <= 1'b1;
      mfo1 <= 1'b1;
      pr(OBJ_DIN, 32'hffbf, 1'b0);
      pw(OBJ_BASE + PAR_IN_MODE, 32'd3, 1'b0);
      pr(OBJ_DIN, 32'hffff, 1'b0);
      mfi1 <= 1'b0;
      pr(OBJ_DIN, 32'hffbf, 1'b0);
      pr(OBJ_DOUT, 32'h00f0, 1'b0);
      pw(OBJ_BASE + PAR_OUT_MODE, 32'd1, 1'b0);
      pr(OBJ_DOUT, 32'h00f4, 1'b0);
      pw(OBJ_DIN, 32'h1, 1'b1);
      pr(16'h1000, 32'h0, 1'b1);
      $display("test state objects done");
   endtask

   task automatic t_stall;
      logic [31:0] s;
      av(1'b1, HR_CMD, {16'h0000, OBJ_DIN}, s);
      av(1'b1, HR_CMD, DOUT_CMD, s);
      s = 32'h1;
      while (s[ST_BUSY] !== 1'b0) av(1'b0, HR_STAT, 32'h0, s);
      `CHK(s[ST_ERR], 1'b0)
      av(1'b0, HR_RDATA, 32'h0, q0);
      `CHK(q0, 32'h000000f4)
      av(1'b0, HR_CMD, 32'h0, q0);
      `CHK(q0, DOUT_CMD)
      av(1'b1, HR_STAT, 32'h2, s);
      av(1'b1, HR_WDATA, 32'h12345678, s);
      av(1'b0, HR_WDATA, 32'h0, q0);
      `CHK(q0, 32'h12345678)
      $display("test command stall done");
   endtask
   task automatic t_reset;
      @(posedge ref_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      pr(M0, 32'h0, 1'b1);
      pr(WS, 32'h0, 1'b0);
      pr(RS, 32'h0, 1'b0);
      $display("test reset done");
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_single();
      t_all();
      t_bad();
      t_state();
      t_stall();
      t_reset();
      results();
   end
   initial begin
      #200000;
      fail_count++;
      results();
   end
endmodule
